// ---- hw/rtccs_pkg.sv ----
// Purpose: Shared constants of the clock control/status register block.
// Assumes: 100 MHz clk, 32.768 kHz oscillator square wave on a pin.
// Notes:   Register byte address is four times the register index.
package rtccs_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int         ADDR_W         = 12;
    localparam logic [9:0] IDX_RATE_OSC   = 10'h00A;
    localparam logic [9:0] IDX_INT_FMT    = 10'h00B;
    localparam logic [9:0] IDX_EVENT      = 10'h00C;
    localparam logic [9:0] IDX_BACKUP     = 10'h00D;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BUSY_POS      = 7;
    localparam int FMT_INHIBIT   = 7;
    localparam int FMT_PER_EN    = 6;
    localparam int FMT_ALM_EN    = 5;
    localparam int FMT_UPD_EN    = 4;
    localparam int FMT_WAVE_EN   = 3;
    localparam int FMT_DATA      = 2;
    localparam int FMT_HOUR      = 1;
    localparam int FMT_DST       = 0;
    localparam int FLG_IRQ       = 3;
    localparam int FLG_PER       = 2;
    localparam int FLG_ALM       = 1;
    localparam int FLG_UPD       = 0;
    localparam int BKP_VALID_POS = 7;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [6:0] RATE_POWER_ON   = 7'h00;
    localparam logic [7:0] FMT_POWER_ON    = 8'h00;
    localparam logic [7:0] FMT_RESET_CLEAR = 8'h78;
    localparam logic [3:0] FLAGS_RESET     = 4'h0;

    // ------------------------------------------------------------------
    // Oscillator, divider and rate select
    // ------------------------------------------------------------------
    localparam logic [2:0]  OSC_RUN        = 3'h2;
    localparam logic [1:0]  OSC_HOLD_TOP   = 2'h3;
    localparam int          DIV_W          = 15;
    localparam logic [14:0] DIV_MAX        = 15'h7FFF;
    localparam logic [14:0] DIV_HALF       = 15'h4000;
    localparam logic [14:0] BUSY_SET_POINT = 15'h7FF8;
    localparam logic [14:0] UPD_END_POINT  = 15'h0040;
    localparam logic [3:0]  RATE_NONE      = 4'h0;
    localparam logic [3:0]  RATE_LOW_LAST  = 4'h2;
    localparam logic [3:0]  RATE_LOW_OFS   = 4'h5;
    localparam logic [3:0]  RATE_HIGH_OFS  = 4'h2;
    localparam logic [1:0]  ALARM_ANY      = 2'h3;

    // ------------------------------------------------------------------
    // Write-protect hold after power returns
    // ------------------------------------------------------------------
    localparam int WP_HOLD_US = 200;
    localparam int CLK_MHZ    = 100;
    localparam int WP_CNT_W   = 20;

endpackage

// ---- hw/rtccs_regs.sv ----
// Purpose: Control/status registers, divider, flags and irq of the clock.
// Assumes: APB master on clk; time and alarm bytes come from same-clock
//          timekeeping logic; pins are synchronised here.
// Notes:   reset_n is the power-on reset; bus_reset_n is the device
//          reset pin that clears only the enables.

module rtccs_regs #(
    parameter int unsigned WP_HOLD_CYCLES =
        rtccs_pkg::WP_HOLD_US * rtccs_pkg::CLK_MHZ
) (
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic                        bus_reset_n,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [rtccs_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        osc_in,
    input  wire logic                        power_fail_level,
    input  wire logic                        backup_valid,
    input  wire logic [7:0]                  time_seconds,
    input  wire logic [7:0]                  time_minutes,
    input  wire logic [7:0]                  time_hours,
    input  wire logic [7:0]                  alarm_seconds,
    input  wire logic [7:0]                  alarm_minutes,
    input  wire logic [7:0]                  alarm_hours,
    output logic                             osc_enable,
    output logic                             divider_run,
    output logic                             update_strobe,
    output logic                             transfer_inhibit,
    output logic                             hour_format,
    output logic                             data_format,
    output logic                             daylight_saving_enable,
    output logic                             write_protect,
    output logic                             square_wave_out,
    output logic                             irq_out,
    output logic                             irq_oe_n
);
    import rtccs_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]          osc_sync;
        logic [1:0]          pwr_sync;
        logic [1:0]          bv_sync;
        logic [1:0]          brst_sync;
        logic                osc_prev;
        logic [6:0]          rate_osc;
        logic [7:0]          int_fmt;
        logic [3:0]          flags;
        logic                busy;
        logic [DIV_W-1:0]    div;
        logic                tap_prev;
        logic [WP_CNT_W-1:0] wp_cnt;
        logic [7:0]          rdata;
        logic                upd_strobe;
        logic                wave;
    } rtccs_state_s;

    rtccs_state_s state_reg;
    rtccs_state_s state_next;

    logic [2:0]  osc_field;
    logic        div_run;
    logic        tick;
    logic [3:0]  rate;
    logic [3:0]  tap_idx;
    logic        tap;
    logic        per_evt;
    logic        upd_start;
    logic        upd_end;
    logic        busy_set;
    logic [2:0]  byte_hit;
    logic [7:0]  cur_byte [3];
    logic [7:0]  alm_byte [3];
    logic        alm_evt;
    logic        access;
    logic [9:0]  idx;
    logic        hit_rate;
    logic        hit_fmt;
    logic        hit_evt;
    logic        hit_bkp;
    logic        wr_ok;
    logic        rd_evt;
    logic [3:0]  clr;
    logic [2:0]  pend;
    logic [7:0]  rd_mux;

    // ------------------------------------------------------------------
    // Oscillator, divider taps and events
    // ------------------------------------------------------------------
    // oscillator field decode
    assign osc_field = state_reg.rate_osc[6:4];
    assign div_run   = osc_field == OSC_RUN;
    assign osc_enable = div_run | (osc_field[2:1] == OSC_HOLD_TOP);
    assign divider_run = div_run;
    // Edge of the synchronised oscillator, counted only while running
    assign tick = state_reg.osc_sync[1] & ~state_reg.osc_prev & div_run;
    // tap mux; codes 1 and 2 alias 256 and 128 Hz
    assign rate    = state_reg.rate_osc[3:0];
    assign tap_idx = (rate <= RATE_LOW_LAST) ? 4'(rate + RATE_LOW_OFS)
                                             : 4'(rate - RATE_HIGH_OFS);
    assign tap     = (rate != RATE_NONE) & state_reg.div[tap_idx];
    // one event per falling tap edge
    assign per_evt = state_reg.tap_prev & ~tap;
    // Update brackets around the 1 Hz rollover
    assign busy_set  = tick & (state_reg.div == BUSY_SET_POINT);
    assign upd_start = tick & (state_reg.div == DIV_MAX);
    assign upd_end   = tick & (state_reg.div == UPD_END_POINT);

    // ------------------------------------------------------------------
    // Alarm comparison
    // ------------------------------------------------------------------
    assign cur_byte[0] = time_seconds;
    assign cur_byte[1] = time_minutes;
    assign cur_byte[2] = time_hours;
    assign alm_byte[0] = alarm_seconds;
    assign alm_byte[1] = alarm_minutes;
    assign alm_byte[2] = alarm_hours;
    for (genvar i = 0; i < 3; i++) begin : g_alarm
        assign byte_hit[i] = (alm_byte[i][7:6] == ALARM_ANY) |
                             (alm_byte[i] == cur_byte[i]);
    end
    assign alm_evt = upd_end & (&byte_hit);

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // no wait states, never blocked by an update
    assign access  = psel & penable;
    assign idx     = paddr[ADDR_W-1:2];
    assign hit_rate = (paddr[1:0] == 2'h0) & (idx == IDX_RATE_OSC);
    assign hit_fmt  = (paddr[1:0] == 2'h0) & (idx == IDX_INT_FMT);
    assign hit_evt  = (paddr[1:0] == 2'h0) & (idx == IDX_EVENT);
    assign hit_bkp  = (paddr[1:0] == 2'h0) & (idx == IDX_BACKUP);
    assign pready  = 1'b1;
    assign pslverr = access & ~(hit_rate | hit_fmt | hit_evt | hit_bkp);
    assign write_protect = state_reg.pwr_sync[1] | (state_reg.wp_cnt != '0);
    assign wr_ok  = access & pwrite & pstrb[0] & ~write_protect;
    assign rd_evt = access & ~pwrite & hit_evt;

    // Read data mux, sampled in the setup cycle
    always_comb begin
        rd_mux = 8'h00;
        if (hit_rate) begin
            rd_mux = {state_reg.busy, state_reg.rate_osc};
        end else if (hit_fmt) begin
            rd_mux = state_reg.int_fmt;
        end else if (hit_evt) begin
            rd_mux = {state_reg.flags, 4'h0};
        end else if (hit_bkp) begin
            rd_mux = {state_reg.bv_sync[1], 7'h00};
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        state_next           = state_reg;
        state_next.osc_sync  = {state_reg.osc_sync[0], osc_in};
        state_next.pwr_sync  = {state_reg.pwr_sync[0], power_fail_level};
        state_next.bv_sync   = {state_reg.bv_sync[0], backup_valid};
        state_next.brst_sync = {state_reg.brst_sync[0], bus_reset_n};
        state_next.osc_prev  = state_reg.osc_sync[1];
        state_next.tap_prev  = tap;
        // hold counter reloads while supply is low
        if (state_reg.pwr_sync[1]) begin
            state_next.wp_cnt = WP_CNT_W'(WP_HOLD_CYCLES);
        end else if (state_reg.wp_cnt != '0) begin
            state_next.wp_cnt = state_reg.wp_cnt - 1'b1;
        end
        if (wr_ok & hit_rate) begin
            state_next.rate_osc = pwdata[6:0];
        end
        // restart at half count so first rollover is 500 ms away
        if (!div_run) begin
            state_next.div = '0;
        end else if (tick) begin
            state_next.div = state_reg.div + 1'b1;
        end
        if (wr_ok & hit_rate & (pwdata[6:4] == OSC_RUN) & !div_run) begin
            state_next.div = DIV_HALF;
        end
        if (wr_ok & hit_fmt) begin
            state_next.int_fmt = pwdata[7:0];
        end
        if (!state_reg.brst_sync[1]) begin
            state_next.int_fmt = state_next.int_fmt & ~FMT_RESET_CLEAR;
        end
        if (state_next.int_fmt[FMT_INHIBIT]) begin
            state_next.int_fmt[FMT_UPD_EN] = 1'b0;
        end
        // busy set before rollover, cleared at update end
        if (busy_set) begin
            state_next.busy = 1'b1;
        end else if (upd_end) begin
            state_next.busy = 1'b0;
        end
        if (state_next.int_fmt[FMT_INHIBIT]) begin
            state_next.busy = 1'b0;
        end
        state_next.upd_strobe = upd_start & ~state_reg.int_fmt[FMT_INHIBIT];
        // clear only what the read reported
        clr = rd_evt ? state_reg.rdata[7:4] : 4'h0;
        state_next.flags[2:0] = (state_reg.flags[2:0] & ~clr[2:0]) |
                                {per_evt, alm_evt, upd_end};
        pend = state_next.flags[2:0] &
               {state_reg.int_fmt[FMT_PER_EN], state_reg.int_fmt[FMT_ALM_EN],
                state_reg.int_fmt[FMT_UPD_EN]};
        state_next.flags[FLG_IRQ] = (state_reg.flags[FLG_IRQ] & ~clr[3]) |
                                    (|pend);
        // Latch read data early so prdata comes from a flop
        if (psel & ~penable & ~pwrite) begin
            state_next.rdata = rd_mux;
        end
        state_next.wave = state_reg.int_fmt[FMT_WAVE_EN] & tap;
    end

    // power-on state has the oscillator stopped
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg        <= '0;
            state_reg.rate_osc <= RATE_POWER_ON;
            state_reg.int_fmt  <= FMT_POWER_ON;
            state_reg.flags  <= FLAGS_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata          = {24'h000000, state_reg.rdata};
    assign update_strobe   = state_reg.upd_strobe;
    assign transfer_inhibit = state_reg.int_fmt[FMT_INHIBIT];
    assign hour_format     = state_reg.int_fmt[FMT_HOUR];
    assign data_format     = state_reg.int_fmt[FMT_DATA];
    assign daylight_saving_enable = state_reg.int_fmt[FMT_DST];
    assign square_wave_out = state_reg.wave;
    // open drain: pull low while a request is pending
    assign irq_out  = 1'b0;
    assign irq_oe_n = ~state_reg.flags[FLG_IRQ];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_busy_inhibit: assert property (
        state_reg.int_fmt[FMT_INHIBIT] |-> !state_reg.busy)
        else $error("busy bit set under inhibit");
    a_uie_cleared: assert property (
        state_reg.int_fmt[FMT_INHIBIT] |-> !state_reg.int_fmt[FMT_UPD_EN])
        else $error("update enable set under inhibit");
    a_wp_block: assert property (
        (access & pwrite & hit_fmt & state_reg.pwr_sync[1] &
         state_reg.brst_sync[1])
        |=> $stable(state_reg.int_fmt))
        else $error("write taken during power fail");
    a_wp_hold: assert property (
        $fell(state_reg.pwr_sync[1]) |-> write_protect [*8])
        else $error("protect released too early");
    a_first_update: assert property (
        (wr_ok & hit_rate & (pwdata[6:4] == OSC_RUN) & !div_run)
        |=> (state_reg.div == DIV_HALF) && divider_run)
        else $error("divider not restarted at half count");
    a_uf_set: assert property (
        upd_end |=> state_reg.flags[FLG_UPD])
        else $error("update flag not set");
    // Only when nothing arrived since the latch may all flags drop
    a_flag_clear: assert property (
        (rd_evt & state_reg.rdata[7] &
         (state_reg.flags == state_reg.rdata[7:4]) &
         !per_evt & !alm_evt & !upd_end)
        |=> !state_reg.flags[FLG_IRQ] && !state_reg.flags[FLG_UPD]
            ##0 irq_oe_n)
        else $error("read did not clear flags");
    a_irq_pending_flag_set: assert property (
        (state_reg.flags[FLG_PER] & state_reg.int_fmt[FMT_PER_EN] & !rd_evt)
        |=> state_reg.flags[FLG_IRQ] && !irq_oe_n)
        else $error("request flag missing");
    a_sqw_low: assert property (
        !state_reg.int_fmt[FMT_WAVE_EN] |=> !square_wave_out)
        else $error("square wave not held low");
    a_rate_none: assert property (
        (rate == RATE_NONE) [*2] |-> !per_evt)
        else $error("periodic event with rate zero");
    a_event_low: assert property (
        (psel & ~penable & ~pwrite & hit_evt) |=> prdata[3:0] == 4'h0)
        else $error("event register low bits set");
    a_backup_zero: assert property (
        (psel & ~penable & ~pwrite & hit_bkp)
        |=> prdata[6:0] == 7'h00 && prdata[7] == $past(state_reg.bv_sync[1]))
        else $error("backup register wrong");

endmodule

// ---- tb/rtccs_osc_model.sv ----
// Purpose: Oscillator and timekeeping side seen by the register block.
// Assumes: Oscillator runs free, sped up to keep runs short.
// Notes:   Alarm bytes are all don't-care, so every update matches.
module rtccs_osc_model #(
    parameter int HALF = 2
) (
    input  wire logic       clk,
    output logic            osc_in,
    output logic      [7:0] time_byte,
    output logic      [7:0] alarm_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;

    // Free-running square wave, HALF clocks per level
    initial osc_in = 1'b0;
    always @(posedge clk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) begin
            osc_in <= ~osc_in;
        end
    end
    assign time_byte  = 8'h12;
    // Both top bits set: byte always matches
    assign alarm_byte = 8'hC0;
endmodule

// ---- tb/rtccs_regs_bench.sv ----
// Purpose: Self-checking bench of the control/status register block.
// Assumes: APB master waits for pready; oscillator sped up to 4 clk period.
// Notes:   Hold interval shortened to 20 cycles through the parameter.
module rtccs_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rtccs_pkg::*;
    logic        clk = 0, reset_n = 0, bus_reset_n = 1;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic        pready, pslverr, err, osc_in, pfail = 0, bvalid = 1;
    logic [7:0]  tbyte, abyte;
    logic        osc_en, div_run, ustrobe, t_inh, h_fmt, d_fmt, dst_en;
    logic        wp, sq_wave;
    logic        irq_out, irq_oe_n;
    int          fails = 0, num_checks = 0, cyc = 0, n;

    always #5 clk = ~clk;

    rtccs_osc_model u_rtccs_osc_model (.clk(clk), .osc_in(osc_in),
        .time_byte(tbyte), .alarm_byte(abyte));
    rtccs_regs #(.WP_HOLD_CYCLES(20)) u_rtccs_regs (
        .clk(clk), .reset_n(reset_n), .bus_reset_n(bus_reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_in(osc_in), .power_fail_level(pfail),
        .backup_valid(bvalid), .time_seconds(tbyte), .time_minutes(tbyte),
        .time_hours(tbyte), .alarm_seconds(abyte), .alarm_minutes(abyte),
        .alarm_hours(abyte), .osc_enable(osc_en), .divider_run(div_run),
        .update_strobe(ustrobe), .transfer_inhibit(t_inh),
        .hour_format(h_fmt), .data_format(d_fmt),
        .daylight_saving_enable(dst_en),
        .write_protect(wp), .square_wave_out(sq_wave), .irq_out(irq_out),
        .irq_oe_n(irq_oe_n));

    // ------------------------------------------------------------------
    // Bus cycles and comparison
    // ------------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // This wait ends as soon as pready is seen high
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        // Let the access edge settle before anyone samples outputs
        @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    // Count cycles with the square wave high over a short window
    task automatic sq_count(output int c);
        c = 0;
        repeat (64) begin
            @(posedge clk);
            if (sq_wave === 1'b1) c++;
        end
    endtask
    task automatic conclude;
        if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Hang guard, well above the 500 ms wait at the sped-up oscillator
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fails++;
            conclude();
        end
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        rd(12'h028, 32'h00); chk(osc_en, 1'b0);
        rd(12'h030, 32'h00); rd(12'h034, 32'h80);
        bvalid <= 1'b0; repeat (4) @(posedge clk);
        rd(12'h034, 32'h00); bvalid <= 1'b1;
        rd(12'h040, 32'h00); chk(err, 1'b1);
        wr(12'h028, 8'hFF); rd(12'h028, 32'h7F);
        chk({osc_en, div_run}, 2'b10);
        wr(12'h028, 8'h20); chk({osc_en, div_run}, 2'b11);
        wr(12'h028, 8'h50); chk({osc_en, div_run}, 2'b00);
        wr(12'h02C, 8'hFF); rd(12'h02C, 32'hEF);
        chk({t_inh, h_fmt, d_fmt, dst_en}, 4'hF);
        wr(12'h02C, 8'h00); chk({t_inh, h_fmt, d_fmt, dst_en}, 4'h0);
        // Write protect during and after a power fail
        pfail <= 1'b1; repeat (4) @(posedge clk);
        wr(12'h02C, 8'h02); rd(12'h02C, 32'h00); chk(wp, 1'b1);
        pfail <= 1'b0;
        wr(12'h02C, 8'h02); rd(12'h02C, 32'h00);
        repeat (30) @(posedge clk);
        wr(12'h02C, 8'h02); rd(12'h02C, 32'h02);
        // Device reset pin clears enables only
        wr(12'h02C, 8'h7F); rd(12'h02C, 32'h7F);
        bus_reset_n <= 1'b0; repeat (6) @(posedge clk);
        bus_reset_n <= 1'b1;
        rd(12'h02C, 32'h07);
        // Periodic flag, square wave and request gating
        wr(12'h02C, 8'h08); wr(12'h028, 8'h23); sq_count(n);
        chk(n != 0, 1'b1);
        wr(12'h028, 8'h20); rd(12'h030, 32'h40);
        rd(12'h030, 32'h00);
        wr(12'h02C, 8'h40); wr(12'h028, 8'h23); sq_count(n);
        chk(n, 0);
        wr(12'h028, 8'h20); chk(irq_oe_n, 1'b0);
        chk(irq_out, 1'b0);
        rd(12'h030, 32'hC0);
        rd(12'h030, 32'h00); chk(irq_oe_n, 1'b1);
        // First update 16384 oscillator periods after starting
        wr(12'h028, 8'h00); wr(12'h02C, 8'h10); wr(12'h028, 8'h20);
        n = 0;
        while (ustrobe !== 1'b1 && n < 70000) begin
            @(posedge clk);
            n++;
        end
        chk(n >= 65520 && n <= 65560, 1'b1);
        rd(12'h028, 32'hA0);
        repeat (300) @(posedge clk);
        rd(12'h028, 32'h20);
        rd(12'h030, 32'hB0);
        conclude();
    end
endmodule
